// ### common/prt_pkg.sv
package prt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CTRL  = 16'h0100;
  localparam logic [15:0] ADDR_IOCTL = 16'h0101;
  localparam logic [15:0] ADDR_MODE  = 16'h0102;
  localparam logic [15:0] ADDR_PRE   = 16'h0103;
  localparam logic [15:0] ADDR_MAIN  = 16'h0104;
  localparam logic [15:0] ADDR_PSEL  = 16'h0180;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_RUN   = 0;
  localparam int BIT_CNTF  = 1;
  localparam int BIT_HALT  = 2;
  localparam int BIT_EDGEF = 4;
  localparam int BIT_UNDF  = 5;
  localparam int BIT_GATE  = 7;
  localparam int MODE_LSB  = 0;
  localparam int CSEL_LSB  = 4;

  // ----------------------------------------------------------------
  // Values after reset, and the mode register write mask
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IOCTL = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_PRE   = 8'hff;
  localparam logic [7:0] RST_MAIN  = 8'hff;
  localparam logic [4:0] RST_PSEL  = 5'h00;
  localparam logic [7:0] MODE_MASK = 8'hf7;

  // ----------------------------------------------------------------
  // Divider counts
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV8_LAST  = 3'h7;
  localparam logic [4:0] DIV32_LAST = 5'h1f;

  // Operating modes
  typedef enum logic [2:0] {
    PRT_MODE_TIMER  = 3'b000,
    PRT_MODE_PULSE  = 3'b001,
    PRT_MODE_EVENT  = 3'b010,
    PRT_MODE_PWIDTH = 3'b011,
    PRT_MODE_PPER   = 3'b100
  } prt_mode_t;

  // Count source codes
  typedef enum logic [2:0] {
    PRT_SRC_F1    = 3'b000,
    PRT_SRC_F8    = 3'b001,
    PRT_SRC_OSC   = 3'b010,
    PRT_SRC_F2    = 3'b011,
    PRT_SRC_SUB32 = 3'b100,
    PRT_SRC_SUB   = 3'b110
  } prt_src_t;

endpackage

// ### design/prt_src_sel.sv
module prt_src_sel (
  input  wire logic       core_clk,       // System clock
  input  wire logic       reset_n,        // Async reset, active low
  input  wire logic [2:0] clk_sel,        // Count source code
  input  wire logic       source_gate,    // 1 cuts the source off
  input  wire logic       onchip_osc_clk, // On-chip oscillator level
  input  wire logic       sub_clk,        // Sub-clock level
  output logic            src_tick        // One-cycle count enable
);

  logic [2:0] div_reg,  div_next;
  logic [4:0] sub_reg,  sub_next;
  logic       osc_reg,  osc_next;
  logic       subd_reg, subd_next;
  logic       tick_reg, tick_next;
  logic       osc_rise;
  logic       sub_rise;

  // ----------------------------------------------------------------
  // Source dividers and selection
  // ----------------------------------------------------------------
  always_comb begin
    osc_rise  = onchip_osc_clk & ~osc_reg;
    sub_rise  = sub_clk & ~subd_reg;
    div_next  = div_reg + 3'h1;
    osc_next  = onchip_osc_clk;
    subd_next = sub_clk;
    sub_next  = sub_rise ? sub_reg + 5'h1 : sub_reg;
    case (prt_pkg::prt_src_t'(clk_sel))
      prt_pkg::PRT_SRC_F1:    tick_next = 1'b1;
      prt_pkg::PRT_SRC_F2:    tick_next = div_reg[0];
      prt_pkg::PRT_SRC_F8:    tick_next = (div_reg == prt_pkg::DIV8_LAST);
      prt_pkg::PRT_SRC_OSC:   tick_next = osc_rise;
      prt_pkg::PRT_SRC_SUB32: tick_next = sub_rise && (sub_reg == prt_pkg::DIV32_LAST);
      prt_pkg::PRT_SRC_SUB:   tick_next = sub_rise;
      default:                tick_next = 1'b0; // Forbidden codes give no source
    endcase
    if (source_gate) begin
      tick_next = 1'b0;
    end
  end

  // Register the divider state and the enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg  <= 3'h0;
      sub_reg  <= 5'h00;
      osc_reg  <= 1'b0;
      subd_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      sub_reg  <= sub_next;
      osc_reg  <= osc_next;
      subd_reg <= subd_next;
      tick_reg <= tick_next;
    end
  end

  assign src_tick = tick_reg;

endmodule

// ### design/prt_timer.sv
// The implementer's own choice: the strobed register port.
module prt_timer (
  input  wire logic        core_clk,       // System clock, 100 MHz
  input  wire logic        reset_n,        // Async reset, active low
  input  wire logic [15:0] reg_addr,       // Register byte address
  input  wire logic [7:0]  reg_wdata,      // Write data
  input  wire logic        reg_wr,         // Write strobe
  input  wire logic        reg_rd,         // Read strobe
  input  wire logic        onchip_osc_clk, // On-chip oscillator level
  input  wire logic        sub_clk,        // Sub-clock level
  output logic [7:0]       reg_rdata,      // Read data, cycle after strobe
  output logic             timer_irq,      // Underflow request pulse
  output logic [1:0]       io_pin_sel,     // Timer pin assignment
  output logic [7:0]       io_control,     // I/O control field copy
  output logic [2:0]       op_mode         // Selected operating mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       run_reg,     run_next;
  logic       cntf_reg,    cntf_next;
  logic       edgef_reg,   edgef_next;
  logic       undf_reg,    undf_next;
  logic [7:0] ioctl_reg,   ioctl_next;
  logic [7:0] mode_reg,    mode_next;
  logic [4:0] psel_reg,    psel_next;
  logic [7:0] pre_rld_reg, pre_rld_next;
  logic [7:0] pre_cnt_reg, pre_cnt_next;
  logic [7:0] tm_rld_reg,  tm_rld_next;
  logic [7:0] tm_cnt_reg,  tm_cnt_next;
  logic       pre_pnd_reg, pre_pnd_next;
  logic       tm_pnd_reg,  tm_pnd_next;
  logic       irq_reg,     irq_next;
  logic [7:0] rdata_reg,   rdata_next;
  logic       src_tick;
  logic       pre_uf;
  logic       tm_uf;
  logic       wr_ctrl;
  logic       wr_pre;
  logic       wr_main;
  logic       halt;

  // ----------------------------------------------------------------
  // Count source selection
  // ----------------------------------------------------------------
  prt_src_sel u_src (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .clk_sel        (mode_reg[prt_pkg::CSEL_LSB +: 3]),
    .source_gate    (mode_reg[prt_pkg::BIT_GATE]),
    .onchip_osc_clk (onchip_osc_clk),
    .sub_clk        (sub_clk),
    .src_tick       (src_tick)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == prt_pkg::ADDR_CTRL);
    wr_pre  = reg_wr && (reg_addr == prt_pkg::ADDR_PRE);
    wr_main = reg_wr && (reg_addr == prt_pkg::ADDR_MAIN);
    halt    = wr_ctrl && reg_wdata[prt_pkg::BIT_HALT];
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    ioctl_next = ioctl_reg;
    mode_next  = mode_reg;
    psel_next  = psel_reg;
    if (reg_wr && (reg_addr == prt_pkg::ADDR_IOCTL)) begin
      ioctl_next = reg_wdata;
    end else if (reg_wr && (reg_addr == prt_pkg::ADDR_MODE)) begin
      mode_next = reg_wdata & prt_pkg::MODE_MASK;
    end else if (reg_wr && (reg_addr == prt_pkg::ADDR_PSEL)) begin
      psel_next = reg_wdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Control, status and flags
  // ----------------------------------------------------------------
  always_comb begin
    run_next   = run_reg;
    cntf_next  = cntf_reg;
    edgef_next = edgef_reg;
    undf_next  = undf_reg;
    if (wr_ctrl) begin
      run_next   = reg_wdata[prt_pkg::BIT_RUN];
      edgef_next = edgef_reg & reg_wdata[prt_pkg::BIT_EDGEF];
      undf_next  = undf_reg & reg_wdata[prt_pkg::BIT_UNDF];
    end
    if (src_tick) begin
      cntf_next = run_reg;
    end
    if (halt) begin
      run_next  = 1'b0;
      cntf_next = 1'b0;
    end
    if (tm_uf) begin
      undf_next = 1'b1; // Set wins over a same-cycle clear
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and timer counting
  // ----------------------------------------------------------------
  always_comb begin
    pre_rld_next = pre_rld_reg;
    pre_cnt_next = pre_cnt_reg;
    tm_rld_next  = tm_rld_reg;
    tm_cnt_next  = tm_cnt_reg;
    pre_pnd_next = pre_pnd_reg;
    tm_pnd_next  = tm_pnd_reg;
    pre_uf       = 1'b0;
    tm_uf        = 1'b0;
    // Prescaler steps on each source tick while running
    if (src_tick && run_reg) begin
      if (pre_pnd_reg) begin
        pre_cnt_next = pre_rld_reg;
        pre_pnd_next = 1'b0;
      end else if (pre_cnt_reg == 8'h00) begin
        pre_cnt_next = pre_rld_reg;
        pre_uf       = 1'b1;
      end else begin
        pre_cnt_next = pre_cnt_reg - 8'h01;
      end
    end
    // Timer steps once per prescaler underflow
    if (pre_uf) begin
      if (tm_pnd_reg) begin
        tm_cnt_next = tm_rld_reg;
        tm_pnd_next = 1'b0;
      end else if (tm_cnt_reg == 8'h00) begin
        tm_cnt_next = tm_rld_reg;
        tm_uf       = 1'b1;
      end else begin
        tm_cnt_next = tm_cnt_reg - 8'h01;
      end
    end
    // Software writes to the prescaler
    if (wr_pre) begin
      pre_rld_next = reg_wdata;
      if (cntf_reg || run_reg) begin
        pre_pnd_next = 1'b1;
      end else begin
        pre_cnt_next = reg_wdata;
      end
    end
    // Software writes to the timer
    if (wr_main) begin
      tm_rld_next = reg_wdata;
      if (cntf_reg || run_reg) begin
        tm_pnd_next = 1'b1;
      end else begin
        tm_cnt_next = reg_wdata;
      end
    end
    // Forced halt restores both stages
    if (halt) begin
      pre_rld_next = prt_pkg::RST_PRE;
      pre_cnt_next = prt_pkg::RST_PRE;
      tm_rld_next  = prt_pkg::RST_MAIN;
      tm_cnt_next  = prt_pkg::RST_MAIN;
      pre_pnd_next = 1'b0;
      tm_pnd_next  = 1'b0;
      pre_uf       = 1'b0;
      tm_uf        = 1'b0;
    end
    irq_next = tm_uf;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (!reg_rd) begin
      rdata_next = 8'h00;
    end else if (reg_addr == prt_pkg::ADDR_CTRL) begin
      rdata_next = {2'h0, undf_reg, edgef_reg, 2'h0, cntf_reg, run_reg};
    end else if (reg_addr == prt_pkg::ADDR_IOCTL) begin
      rdata_next = ioctl_reg;
    end else if (reg_addr == prt_pkg::ADDR_MODE) begin
      rdata_next = mode_reg;
    end else if (reg_addr == prt_pkg::ADDR_PRE) begin
      rdata_next = pre_cnt_reg;
    end else if (reg_addr == prt_pkg::ADDR_MAIN) begin
      rdata_next = tm_cnt_reg;
    end else if (reg_addr == prt_pkg::ADDR_PSEL) begin
      rdata_next = {3'h0, psel_reg};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg     <= 1'b0;
      cntf_reg    <= 1'b0;
      edgef_reg   <= 1'b0;
      undf_reg    <= 1'b0;
      ioctl_reg   <= prt_pkg::RST_IOCTL;
      mode_reg    <= prt_pkg::RST_MODE;
      psel_reg    <= prt_pkg::RST_PSEL;
      pre_rld_reg <= prt_pkg::RST_PRE;
      pre_cnt_reg <= prt_pkg::RST_PRE;
      tm_rld_reg  <= prt_pkg::RST_MAIN;
      tm_cnt_reg  <= prt_pkg::RST_MAIN;
      pre_pnd_reg <= 1'b0;
      tm_pnd_reg  <= 1'b0;
      irq_reg     <= 1'b0;
      rdata_reg   <= 8'h00;
    end else begin
      run_reg     <= run_next;
      cntf_reg    <= cntf_next;
      edgef_reg   <= edgef_next;
      undf_reg    <= undf_next;
      ioctl_reg   <= ioctl_next;
      mode_reg    <= mode_next;
      psel_reg    <= psel_next;
      pre_rld_reg <= pre_rld_next;
      pre_cnt_reg <= pre_cnt_next;
      tm_rld_reg  <= tm_rld_next;
      tm_cnt_reg  <= tm_cnt_next;
      pre_pnd_reg <= pre_pnd_next;
      tm_pnd_reg  <= tm_pnd_next;
      irq_reg     <= irq_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign reg_rdata  = rdata_reg;
  assign timer_irq  = irq_reg;
  assign io_pin_sel = psel_reg[1:0];
  assign io_control = ioctl_reg;
  assign op_mode    = mode_reg[prt_pkg::MODE_LSB +: 3];

endmodule

// ### test/prt_timer_props.sv
module prt_timer_props (
  input wire logic        core_clk,       // System clock
  input wire logic        reset_n,        // Async reset, active low
  input wire logic [15:0] reg_addr,       // Register address
  input wire logic [7:0]  reg_wdata,      // Write data
  input wire logic        reg_wr,         // Write strobe
  input wire logic        reg_rd,         // Read strobe
  input wire logic        onchip_osc_clk, // Oscillator level
  input wire logic        sub_clk,        // Sub-clock level
  input wire logic [7:0]  reg_rdata,      // Read data
  input wire logic        timer_irq,      // Underflow pulse
  input wire logic [1:0]  io_pin_sel,     // Pin assignment
  input wire logic [7:0]  io_control,     // I/O control copy
  input wire logic [2:0]  op_mode         // Mode field
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Port checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_ctrl_empty_bits: assert property (reg_rd && reg_addr == prt_pkg::ADDR_CTRL
    |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0) else $error("control bits not 0");
  a_mode_b3_zero: assert property (reg_rd && reg_addr == prt_pkg::ADDR_MODE
    |=> reg_rdata[3] == 1'b0) else $error("mode bit 3 not 0");
  a_mode_takes_write: assert property (reg_wr && reg_addr == prt_pkg::ADDR_MODE
    |=> op_mode == $past(reg_wdata[2:0])) else $error("mode output wrong");
  a_psel_takes_write: assert property (reg_wr && reg_addr == prt_pkg::ADDR_PSEL
    |=> io_pin_sel == $past(reg_wdata[1:0])) else $error("pin select wrong");
  a_psel_holds: assert property (!(reg_wr && reg_addr == prt_pkg::ADDR_PSEL)
    |=> $stable(io_pin_sel)) else $error("pin select moved");
  // A stopped counter raises no request once the last in-flight pulse has gone
  a_stop_irq_quiet: assert property (reg_wr && reg_addr == prt_pkg::ADDR_CTRL
    && !reg_wdata[prt_pkg::BIT_RUN] |=> ##1 !timer_irq) else $error("interrupt after stop");
  a_halt_quiet: assert property (reg_wr && reg_addr == prt_pkg::ADDR_CTRL && reg_wdata[2]
    |=> !timer_irq [*3]) else $error("interrupt after forced halt");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h0105
    |=> reg_rdata == 8'h00) else $error("unmapped read not 0");

  c_irq: cover property (timer_irq);
  c_halt: cover property (reg_wr && reg_addr == prt_pkg::ADDR_CTRL && reg_wdata[2]);
  c_pre_read: cover property (reg_rd && reg_addr == prt_pkg::ADDR_PRE);
endmodule

// ### test/tb_prt_timer.sv
module tb_prt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, reset_n, reg_wr, reg_rd, onchip_osc_clk, sub_clk, timer_irq;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, io_control, d;
  logic [1:0]  io_pin_sel;
  logic [2:0]  op_mode;
  int          n_mismatch, checks, ph, c;

  prt_timer DUT (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .onchip_osc_clk, .sub_clk, .reg_rdata, .timer_irq, .io_pin_sel, .io_control, .op_mode);

  // ----------------------------------------
  // Clock, slow sources, watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Oscillator period 6 cycles, sub-clock period 10 cycles
  always @(posedge core_clk) begin
    ph <= ph + 1;
    onchip_osc_clk <= (ph % 6) < 3;
    sub_clk <= (ph % 10) < 5;
  end
  initial begin
    #300us;
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Step off the edge so a caller never samples outputs in the launching time step
    #1;
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(nm, {8'h00, d}, {8'h00, e});
  endtask
  // Cycles between two successive interrupt pulses, bounded
  task automatic gap();
    c = 0;
    do @(posedge core_clk) #1 c++; while (timer_irq !== 1'b1 && c < 2000);
    c = 0;
    do @(posedge core_clk) #1 c++; while (timer_irq !== 1'b1 && c < 2000);
  endtask
  // Halt stops at once, so the mode register may then be rewritten
  task automatic setup(input logic [7:0] mode, input logic [7:0] n, input logic [7:0] m);
    wr(prt_pkg::ADDR_CTRL, 8'h04);
    wr(prt_pkg::ADDR_MODE, mode);
    wr(prt_pkg::ADDR_PRE, n);
    wr(prt_pkg::ADDR_MAIN, m);
    wr(prt_pkg::ADDR_CTRL, 8'h01);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] ad[7] = '{16'h0100, 16'h0101, 16'h0102, 16'h0103, 16'h0104, 16'h0180, 16'h0105};
    logic [7:0]  ev[7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) rchk("reset value", ad[i], ev[i]);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(prt_pkg::ADDR_PSEL, 8'hfe);
    rchk("pin select", prt_pkg::ADDR_PSEL, 8'h1e);
    chk("pin port", {14'h0, io_pin_sel}, 16'h0002);
    wr(prt_pkg::ADDR_IOCTL, 8'ha5);
    rchk("io control", prt_pkg::ADDR_IOCTL, 8'ha5);
    chk("io port", {8'h00, io_control}, 16'h00a5);
    for (int m = 0; m < 5; m++) begin
      wr(prt_pkg::ADDR_MODE, 8'(m));
      chk("mode port", {13'h0, op_mode}, 16'(m));
    end
    wr(prt_pkg::ADDR_MODE, 8'hff);
    rchk("mode reg", prt_pkg::ADDR_MODE, 8'hf7);
    wr(prt_pkg::ADDR_CTRL, 8'h30);
    rchk("flags keep", prt_pkg::ADDR_CTRL, 8'h00);
    wr(prt_pkg::ADDR_PRE, 8'h12);
    wr(prt_pkg::ADDR_MAIN, 8'h34);
    rchk("pre load", prt_pkg::ADDR_PRE, 8'h12);
    rchk("main load", prt_pkg::ADDR_MAIN, 8'h34);
    wr(prt_pkg::ADDR_CTRL, 8'h01);
    rchk("run no source", prt_pkg::ADDR_CTRL, 8'h01);
    wr(prt_pkg::ADDR_CTRL, 8'h04);
    rchk("halt ctrl", prt_pkg::ADDR_CTRL, 8'h00);
    rchk("halt pre", prt_pkg::ADDR_PRE, 8'hff);
    rchk("halt main", prt_pkg::ADDR_MAIN, 8'hff);
    $display("test registers done");
  endtask
  task automatic t_sources();
    logic [7:0] cd[6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h60};
    int         pd[6] = '{2, 16, 12, 4, 640, 20};
    for (int i = 0; i < 6; i++) begin
      setup(cd[i], 8'h00, 8'h01);
      gap();
      chk("source period", 16'(c), 16'(pd[i]));
    end
    for (int i = 0; i < 2; i++) begin
      setup(i ? 8'h50 : 8'h80, 8'h00, 8'h01);
      repeat (40) @(posedge core_clk);
      rchk("cut main", prt_pkg::ADDR_MAIN, 8'h01);
    end
    $display("test sources done");
  endtask
  task automatic t_period();
    setup(8'h00, 8'h02, 8'h03);
    gap();
    chk("period", 16'(c), 16'd12);
    rchk("running", prt_pkg::ADDR_CTRL, 8'h23);
    wr(prt_pkg::ADDR_MAIN, 8'h00);
    gap();
    gap();
    chk("rewrite period", 16'(c), 16'd3);
    wr(prt_pkg::ADDR_CTRL, 8'h20);
    rchk("stopped", prt_pkg::ADDR_CTRL, 8'h20);
    wr(prt_pkg::ADDR_CTRL, 8'h00);
    rchk("flag clear", prt_pkg::ADDR_CTRL, 8'h00);
    $display("test period done");
  endtask

  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_sources();
    t_period();
    finish_test();
  end
endmodule

bind prt_timer prt_timer_props u_props (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .onchip_osc_clk, .sub_clk, .reg_rdata, .timer_irq, .io_pin_sel, .io_control,
  .op_mode);
